/* chop_seq_consts.vh */
// register map, field positions and timing constants of the sequencer
`ifndef CHOP_SEQ_CONSTS_VH
`define CHOP_SEQ_CONSTS_VH
`define IDX_CTRL 6'h00
`define IDX_CONV 6'h01
`define IDX_STEPEN 6'h02
`define IDX_STAT 6'h03
`define IDX_OSR 6'h04
`define IDX_MAIN 6'h05
`define IDX_RES_LO 6'h10
`define IDX_RES_HI 6'h1f
`define IDX_CFG_LO 6'h20
`define IDX_CFG_HI 6'h2f
`define CTRL_CHOP 0
`define CTRL_CDLY 3:1
`define CTRL_AEN 4
`define CTRL_MODE 6:5
`define CTRL_MDLY 9:7
`define CTRL_OPM 11:10
`define CTRL_OCN 15:12
`define CTRL_RST 16'h0010
`define CV_MSTART 0
`define CV_MSTOP 1
`define CV_SSTART 2
`define CV_SSTOP 3
`define MODE_CONT 2'h0
`define MODE_SYNC 2'h2
`define OPM_ACTIVE 2'h0
`define OSR_RST 16'h0080
`define MAIN_LAT 20'h0002c
`define FILT_PER 20'h00003
`define CHOP_BASE 20'h00010
`define MUX_BASE 20'h00008
`define FAST_SKIP 2'h2
`define NO_STEP 5'h10
`endif

/* chop_and_channel_sequencer.v */
// chop control of the main converter and step sequencer of the aux one
// Functional notes
// - chop on: conversion pairs with alternating polarity, first one normal.
// - between pair halves swap polarity and reset the digital filter.
// - first chopped conversion withheld; each output is half the difference.
// - first chopped result after 2*(delay+3*OSR) plus 44 modulator cycles.
// - after each inversion wait the three-bit chop settle delay.
// - fast filter reset per inversion; first two results skip the count.
// - sixteen steps with own enables, one conversion per enabled step.
// - each step applies its own gain and input selection before converting.
// - runs start at step 0, ascend, and skip disabled steps.
// - mux settle delay from one shared three-bit field before each step.
// - sequence-active bit high while a run is in progress.
// - start written while aux converter disabled does not start a run.
// - 16-bit step results at indices 10h-1Fh; disabled steps give 0000h.
// - results all update at run end; reads never mix two runs.
// - two-bit mode selects continuous, single-shot or synchronized.
// - continuous repeats runs; start during a run restarts it.
// - stop lets the run finish; stop bit reads 1 until halted.
// - aux disable, standby or power-down aborts a run at once.
// - results persist; cleared only by reset, disable, standby, power-down.
// - start and stop in one write: start wins.
// - single-shot: one run per start, start restarts, stop ignored.
// - synchronized: main conversion starts trigger a run only when idle.
// - start commands act at the completing edge of the control write.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "chop_seq_consts.vh"
module chop_and_channel_sequencer #(
	parameter MAIN_W = 24,
	parameter AUX_W  = 16,
	parameter CFG_W  = 12
) (
	input  wire              clk_in,
	input  wire              rst_in,
	input  wire              psel_in,
	input  wire              penable_in,
	input  wire              pwrite_in,
	input  wire [7:0]        paddr_in,
	input  wire [31:0]       pwdata_in,
	output reg  [31:0]       prdata_out,
	output reg               pready_out,
	output reg               pslverr_out,
	input  wire              main_done_in,
	input  wire [MAIN_W-1:0] main_data_in,
	input  wire              fast_done_in,
	input  wire              fast_over_in,
	input  wire              aux_done_in,
	input  wire [AUX_W-1:0]  aux_data_in,
	output reg               main_polarity_out,
	output reg               main_filter_rst_out,
	output reg               main_conv_start_out,
	output reg               main_drdy_out,
	output reg  [MAIN_W-1:0] main_result_out,
	output reg               fast_filter_rst_out,
	output reg               overcurrent_out,
	output reg               aux_start_out,
	output reg  [CFG_W-1:0]  aux_cfg_out,
	output reg               sequence_active_flag_out
);
	localparam M_IDLE = 2'h0;
	localparam M_DLY  = 2'h1;
	localparam M_CONV = 2'h2;
	localparam S_IDLE = 2'h0;
	localparam S_MUX  = 2'h1;
	localparam S_CONV = 2'h2;
	localparam S_DONE = 2'h3;

	reg  [15:0]       ctrl_ff;
	reg  [15:0]       step_enable_ff;
	reg  [15:0]       osr_ff;
	reg  [CFG_W-1:0]  cfg_mem [0:15];
	reg  [AUX_W-1:0]  shadow_mem [0:15];
	reg  [AUX_W-1:0]  result_mem [0:15];
	reg  [1:0]        mst_ff;
	reg  [19:0]       mcnt_ff;
	reg               first_ff;
	reg               have_prev_ff;
	reg  [MAIN_W-1:0] prev_ff;
	reg               mstop_ff;
	reg  [1:0]        skip_ff;
	reg  [3:0]        occ_ff;
	reg  [1:0]        sst_ff;
	reg  [3:0]        step_ff;
	reg  [19:0]       scnt_ff;
	reg               armed_ff;
	reg               sstop_ff;
	reg  [31:0]       rd_mux;
	reg               rd_err;

	wire [5:0]  idx = paddr_in[7:2];
	wire        acc = psel_in & penable_in & pready_out;
	wire        wr = acc & pwrite_in;
	wire        wr_conv = wr & (idx == `IDX_CONV);
	wire        chop = ctrl_ff[`CTRL_CHOP];
	wire [1:0]  mode = ctrl_ff[`CTRL_MODE];
	wire        main_off = ctrl_ff[`CTRL_OPM] != `OPM_ACTIVE;
	wire        aux_off = ~ctrl_ff[`CTRL_AEN] | main_off;
	wire        m_start = wr_conv & pwdata_in[`CV_MSTART];
	wire        s_start = wr_conv & pwdata_in[`CV_SSTART];
	wire [19:0] chop_dly = `CHOP_BASE << ctrl_ff[`CTRL_CDLY];
	wire [19:0] mux_dly = `MUX_BASE << ctrl_ff[`CTRL_MDLY];
	wire [19:0] osr20 = {4'h0, osr_ff};
	wire [19:0] conv_len = (first_ff | chop) ?
		osr20 * `FILT_PER + (`MAIN_LAT >> 1) : osr20;
	wire [MAIN_W-1:0] nrm = main_polarity_out ? prev_ff : main_data_in;
	wire [MAIN_W-1:0] inv = main_polarity_out ? main_data_in : prev_ff;
	wire [MAIN_W:0]   diff = {nrm[MAIN_W-1], nrm} - {inv[MAIN_W-1], inv};
	wire              conv_end = (mst_ff == M_CONV) & main_done_in &
		(mcnt_ff >= conv_len - 20'h1);

	function [4:0] next_step;
		input [15:0] mask;
		input [4:0]  from;
		integer      i;
		begin
			next_step = `NO_STEP;
			// lowest enabled step at or above from
			for (i = 15; i >= 0; i = i - 1) begin
				if (mask[i] && (i >= from))
					next_step = i[4:0];
			end
		end
	endfunction

	wire [4:0] first_step = next_step(step_enable_ff, 5'h00);
	wire [4:0] later_step = next_step(step_enable_ff,
		{1'b0, step_ff} + 5'h01);

	// apb slave: one wait state, writes land with pready
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= psel_in & penable_in & ~pready_out;
			prdata_out  <= rd_mux;
			pslverr_out <= psel_in & penable_in & ~pready_out & rd_err;
		end
	end

	always @* begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		if (idx == `IDX_CTRL)
			rd_mux = {16'h0000, ctrl_ff};
		else if (idx == `IDX_CONV)
			rd_mux = {28'h0000000, sstop_ff, 1'b0, mstop_ff, 1'b0};
		else if (idx == `IDX_STEPEN)
			rd_mux = {16'h0000, step_enable_ff};
		else if (idx == `IDX_STAT)
			rd_mux = {27'h0000000, overcurrent_out, main_polarity_out,
				mst_ff != M_IDLE, armed_ff, sequence_active_flag_out};
		else if (idx == `IDX_OSR)
			rd_mux = {16'h0000, osr_ff};
		else if (idx == `IDX_MAIN)
			rd_mux = {{(32-MAIN_W){1'b0}}, main_result_out};
		else if (idx >= `IDX_RES_LO && idx <= `IDX_RES_HI)
			rd_mux = {{(32-AUX_W){1'b0}}, result_mem[idx[3:0]]};
		else if (idx >= `IDX_CFG_LO && idx <= `IDX_CFG_HI)
			rd_mux = {{(32-CFG_W){1'b0}}, cfg_mem[idx[3:0]]};
		else
			rd_err = 1'b1;
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_ff        <= `CTRL_RST;
			step_enable_ff <= 16'h0000;
			osr_ff         <= `OSR_RST;
		end else if (wr) begin
			if (idx == `IDX_CTRL)
				ctrl_ff <= pwdata_in[15:0];
			if (idx == `IDX_STEPEN)
				step_enable_ff <= pwdata_in[15:0];
			if (idx == `IDX_OSR)
				osr_ff <= pwdata_in[15:0];
		end
	end

	// per-step configuration, shadow and published results
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : step_g
			always @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					cfg_mem[g]    <= {CFG_W{1'b0}};
					shadow_mem[g] <= {AUX_W{1'b0}};
					result_mem[g] <= {AUX_W{1'b0}};
				end else begin
					if (wr && idx == `IDX_CFG_LO + g)
						cfg_mem[g] <= pwdata_in[CFG_W-1:0];
					if (sst_ff == S_CONV && aux_done_in && step_ff == g)
						shadow_mem[g] <= aux_data_in;
					// cleared only on disable or low power
					if (aux_off)
						result_mem[g] <= {AUX_W{1'b0}};
					// all results commit at run end
					else if (sst_ff == S_DONE)
						result_mem[g] <= step_enable_ff[g] ?
							shadow_mem[g] : {AUX_W{1'b0}};
				end
			end
		end
	endgenerate

	// main converter control
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mst_ff              <= M_IDLE;
			mcnt_ff             <= 20'h00000;
			first_ff            <= 1'b0;
			have_prev_ff        <= 1'b0;
			prev_ff             <= {MAIN_W{1'b0}};
			mstop_ff            <= 1'b0;
			main_polarity_out   <= 1'b0;
			main_filter_rst_out <= 1'b0;
			main_conv_start_out <= 1'b0;
			main_drdy_out       <= 1'b0;
			main_result_out     <= {MAIN_W{1'b0}};
			fast_filter_rst_out <= 1'b0;
		end else begin
			main_filter_rst_out <= 1'b0;
			main_conv_start_out <= 1'b0;
			main_drdy_out       <= 1'b0;
			fast_filter_rst_out <= 1'b0;
			mcnt_ff             <= mcnt_ff + 20'h1;
			if (main_off) begin
				mst_ff   <= M_IDLE;
				mstop_ff <= 1'b0;
				main_result_out <= {MAIN_W{1'b0}};
			end else if (m_start) begin
				// start beats a stop in the same write
				mstop_ff            <= 1'b0;
				main_polarity_out   <= 1'b0;
				main_filter_rst_out <= 1'b1;
				fast_filter_rst_out <= chop;
				first_ff            <= 1'b1;
				have_prev_ff        <= 1'b0;
				mcnt_ff             <= 20'h00000;
				mst_ff              <= chop ? M_DLY : M_CONV;
				main_conv_start_out <= ~chop;
			end else begin
				if (wr_conv && pwdata_in[`CV_MSTOP] && mst_ff != M_IDLE)
					mstop_ff <= 1'b1;
				case (mst_ff)
				M_DLY: begin
					if (mcnt_ff >= chop_dly - 20'h1) begin
						mst_ff              <= M_CONV;
						mcnt_ff             <= 20'h00000;
						main_conv_start_out <= 1'b1;
					end
				end
				M_CONV: begin
					if (conv_end) begin
						prev_ff  <= main_data_in;
						first_ff <= 1'b0;
						mcnt_ff  <= 20'h00000;
						if (chop) begin
							have_prev_ff <= 1'b1;
							main_drdy_out <= have_prev_ff;
							if (have_prev_ff)
								main_result_out <= diff[MAIN_W:1];
							main_polarity_out   <= ~main_polarity_out;
							main_filter_rst_out <= 1'b1;
							fast_filter_rst_out <= 1'b1;
						end else begin
							main_drdy_out   <= 1'b1;
							main_result_out <= main_data_in;
						end
						if (mstop_ff) begin
							mst_ff   <= M_IDLE;
							mstop_ff <= 1'b0;
						end else if (chop) begin
							mst_ff <= M_DLY;
						end else begin
							main_conv_start_out <= 1'b1;
						end
					end
				end
				default: begin
					mst_ff <= M_IDLE;
				end
				endcase
			end
		end
	end

	// overcurrent count with post-reset skip
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			skip_ff         <= 2'h0;
			occ_ff          <= 4'h0;
			overcurrent_out <= 1'b0;
		end else begin
			overcurrent_out <= (occ_ff >= ctrl_ff[`CTRL_OCN]) &
				(ctrl_ff[`CTRL_OCN] != 4'h0);
			if (fast_filter_rst_out) begin
				skip_ff <= `FAST_SKIP;
			end else if (fast_done_in) begin
				if (skip_ff != 2'h0)
					skip_ff <= skip_ff - 2'h1;
				else if (fast_over_in && occ_ff != 4'hf)
					occ_ff <= occ_ff + 4'h1;
				else if (!fast_over_in)
					occ_ff <= 4'h0;
			end
		end
	end

	// aux converter sequencer
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sst_ff                   <= S_IDLE;
			step_ff                  <= 4'h0;
			scnt_ff                  <= 20'h00000;
			armed_ff                 <= 1'b0;
			sstop_ff                 <= 1'b0;
			aux_start_out            <= 1'b0;
			aux_cfg_out              <= {CFG_W{1'b0}};
			sequence_active_flag_out <= 1'b0;
		end else begin
			aux_start_out <= 1'b0;
			scnt_ff       <= scnt_ff + 20'h1;
			sequence_active_flag_out <= (sst_ff != S_IDLE) & ~aux_off;
			if (aux_off) begin
				sst_ff   <= S_IDLE;
				armed_ff <= 1'b0;
				sstop_ff <= 1'b0;
			end else if (s_start) begin
				// single shot restarts the same way
				sstop_ff <= 1'b0;
				armed_ff <= mode == `MODE_SYNC;
				scnt_ff  <= 20'h00000;
				step_ff  <= first_step[3:0];
				aux_cfg_out <= cfg_mem[first_step[3:0]];
				sst_ff   <= (first_step == `NO_STEP) ? S_DONE : S_MUX;
			end else begin
				if (wr_conv && pwdata_in[`CV_SSTOP] && sst_ff != S_IDLE &&
					mode == `MODE_CONT)
					sstop_ff <= 1'b1;
				case (sst_ff)
				S_IDLE: begin
					if (armed_ff && mode == `MODE_SYNC &&
						main_conv_start_out) begin
						scnt_ff <= 20'h00000;
						step_ff <= first_step[3:0];
						aux_cfg_out <= cfg_mem[first_step[3:0]];
						sst_ff  <= (first_step == `NO_STEP) ? S_DONE : S_MUX;
					end
				end
				S_MUX: begin
					if (scnt_ff >= mux_dly - 20'h1) begin
						aux_start_out <= 1'b1;
						sst_ff        <= S_CONV;
					end
				end
				S_CONV: begin
					if (aux_done_in) begin
						scnt_ff <= 20'h00000;
						if (later_step == `NO_STEP) begin
							sst_ff <= S_DONE;
						end else begin
							step_ff <= later_step[3:0];
							aux_cfg_out <= cfg_mem[later_step[3:0]];
							sst_ff  <= S_MUX;
						end
					end
				end
				default: begin
					scnt_ff <= 20'h00000;
					// mode decides what follows a run
					if (mode == `MODE_CONT && !sstop_ff) begin
						step_ff <= first_step[3:0];
						aux_cfg_out <= cfg_mem[first_step[3:0]];
						sst_ff  <= (first_step == `NO_STEP) ? S_DONE : S_MUX;
					end else begin
						sst_ff   <= S_IDLE;
						sstop_ff <= 1'b0;
					end
				end
				endcase
			end
		end
	end
endmodule // chop_and_channel_sequencer

/* chop_seq_checker.sv */
// assertion checker for the chop and step sequencer block
`timescale 1ns/100ps
module chop_seq_checker #(
	parameter CFG_W = 12
) (
	input wire logic             clk_in,
	input wire logic             rst_in,
	input wire logic             psel_in,
	input wire logic             penable_in,
	input wire logic             pready_out,
	input wire logic             pslverr_out,
	input wire logic             main_polarity_out,
	input wire logic             main_filter_rst_out,
	input wire logic             main_conv_start_out,
	input wire logic             fast_filter_rst_out,
	input wire logic             aux_start_out,
	input wire logic [CFG_W-1:0] aux_cfg_out,
	input wire logic             sequence_active_flag_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence quiet_aux;
		!aux_start_out [*8];
	endsequence
	sequence quiet_main;
		!main_conv_start_out [*8];
	endsequence
	a_ready_wait: assert property (psel_in && $rose(penable_in) |=> pready_out)
		else $error("ready not after one wait state");
	a_ready_idle: assert property (!psel_in |-> !pready_out)
		else $error("ready without select");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	a_pol_filter: assert property ($rose(main_polarity_out) |->
		(main_filter_rst_out || $past(main_filter_rst_out))
		or (##1 main_filter_rst_out)) else $error("no filter reset");
	a_fast_inv: assert property ($rose(main_polarity_out) |->
		(fast_filter_rst_out || $past(fast_filter_rst_out))
		or (##1 fast_filter_rst_out)) else $error("no fast reset");
	a_chop_settle: assert property (fast_filter_rst_out |=> quiet_main)
		else $error("conversion before settle delay");
	a_mux_gap: assert property (aux_start_out |=> quiet_aux)
		else $error("step start without mux delay");
	a_cfg_hold: assert property (aux_start_out |-> $stable(aux_cfg_out))
		else $error("config moved at step start");
	a_active_run: assert property (aux_start_out |->
		sequence_active_flag_out [*2]) else $error("active low in run");
endmodule // chop_seq_checker

bind chop_and_channel_sequencer chop_seq_checker #(.CFG_W(CFG_W)) chk_u (
	.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .main_polarity_out(main_polarity_out),
	.main_filter_rst_out(main_filter_rst_out),
	.main_conv_start_out(main_conv_start_out),
	.fast_filter_rst_out(fast_filter_rst_out),
	.aux_start_out(aux_start_out), .aux_cfg_out(aux_cfg_out),
	.sequence_active_flag_out(sequence_active_flag_out));

/* chop_and_channel_sequencer_bench.sv */
// self-checking bench for the chop and step sequencer block
`timescale 1ns/100ps
`include "chop_seq_consts.vh"
module chop_and_channel_sequencer_bench;
	typedef struct {logic [5:0] a; logic [31:0] d; logic e;} row_t;
	logic        clk_in = 0, rst_in = 1;
	logic        psel_in = 0, penable_in = 0, pwrite_in = 0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rdata;
	logic        pready_out, pslverr_out, rerr;
	logic        main_done_in = 0, fast_done_in = 0, aux_done_in = 0;
	logic        fast_over_in = 1;
	logic [23:0] main_data_in = 24'h0, main_result_out;
	logic [15:0] aux_data_in = 16'h0;
	logic [11:0] aux_cfg_out;
	logic        main_polarity_out, main_filter_rst_out, main_conv_start_out;
	logic        main_drdy_out, fast_filter_rst_out, overcurrent_out;
	logic        aux_start_out, sequence_active_flag_out;
	logic [11:0] cfg_seen[$];
	int          mismatches = 0, num_checks = 0, mcnt = 0, acnt = 0, n;
	int          fcnt = 0;
	row_t        rows[6];
	always #5 clk_in = ~clk_in;
	chop_and_channel_sequencer dut_u (.clk_in(clk_in), .rst_in(rst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.main_done_in(main_done_in), .main_data_in(main_data_in),
		.fast_done_in(fast_done_in), .fast_over_in(fast_over_in),
		.aux_done_in(aux_done_in), .aux_data_in(aux_data_in),
		.main_polarity_out(main_polarity_out),
		.main_filter_rst_out(main_filter_rst_out),
		.main_conv_start_out(main_conv_start_out),
		.main_drdy_out(main_drdy_out), .main_result_out(main_result_out),
		.fast_filter_rst_out(fast_filter_rst_out),
		.overcurrent_out(overcurrent_out), .aux_start_out(aux_start_out),
		.aux_cfg_out(aux_cfg_out),
		.sequence_active_flag_out(sequence_active_flag_out));
	// converters: main samples at a fixed rate, aux answers in 5 cycles
	always @(posedge clk_in) begin
		mcnt <= (mcnt == 49) ? 0 : mcnt + 1;
		main_done_in <= (mcnt == 0);
		fast_done_in <= (mcnt % 8 == 0);
		main_data_in <= main_polarity_out ? -24'sd100 : 24'sd300;
		acnt <= aux_start_out ? 4 : (acnt > 0 ? acnt - 1 : 0);
		aux_done_in <= (acnt == 1);
		aux_data_in <= {4'h5, aux_cfg_out};
		if (aux_start_out)
			cfg_seen.push_back(aux_cfg_out);
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// one edge first, so a strobe is never set and cleared in one step
	task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_in);
		psel_in <= 1;
		pwrite_in <= w;
		paddr_in <= {idx, 2'b00};
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready_out !== 1'b1 && k < 20);
		if (k == 20) begin
			mismatches++;
			test_done;
		end
		rdata = prdata_out;
		rerr = pslverr_out;
		psel_in <= 0;
		penable_in <= 0;
	endtask
	task wait_lvl(input logic want, input int lim);
		int k;
		k = 0;
		while (sequence_active_flag_out !== want) begin
			@(posedge clk_in);
			k++;
			if (k > lim) begin
				mismatches++;
				test_done;
			end
		end
	endtask
	initial begin
		rows = '{'{`IDX_CTRL, `CTRL_RST, 0}, '{`IDX_OSR, `OSR_RST, 0},
			'{`IDX_RES_LO, 0, 0}, '{`IDX_RES_HI, 0, 0},
			'{`IDX_STAT, 0, 0}, '{6'h06, 0, 1}};
		repeat (12) @(posedge clk_in);
		rst_in <= 0;
		foreach (rows[i]) begin
			apb(0, rows[i].a, 0);
			chk(rdata, rows[i].d);
			chk(rerr, rows[i].e);
		end
		for (int i = 0; i < 16; i++)
			apb(1, 6'(`IDX_CFG_LO + i), 32'(32'h300 + 17 * i));
		apb(1, `IDX_STEPEN, 32'h8005);
		apb(1, `IDX_CTRL, 32'h30);
		apb(1, `IDX_CONV, 32'h4);
		// the flag follows the run state one clock later
		repeat (2) @(posedge clk_in);
		chk(sequence_active_flag_out, 1);
		apb(0, `IDX_RES_LO, 0);
		chk(rdata, 0);
		wait_lvl(0, 500);
		chk(cfg_seen.size(), 3);
		chk(cfg_seen[0], 32'h300);
		chk(cfg_seen[1], 32'h322);
		chk(cfg_seen[2], 32'h3ff);
		for (int i = 0; i < 16; i++) begin
			apb(0, 6'(`IDX_RES_LO + i), 0);
			chk(rdata, (i == 0 || i == 2 || i == 15) ? 32'h5300 + 17 * i : 0);
		end
		// continuous: start plus stop keeps it running
		apb(1, `IDX_CTRL, 32'h10);
		apb(1, `IDX_CONV, 32'h4);
		apb(1, `IDX_CONV, 32'hc);
		repeat (200) @(posedge clk_in);
		chk(sequence_active_flag_out, 1);
		apb(1, `IDX_CONV, 32'h8);
		apb(0, `IDX_CONV, 0);
		chk(rdata[3], 1);
		wait_lvl(0, 300);
		apb(0, `IDX_CONV, 0);
		chk(rdata[3], 0);
		apb(0, `IDX_RES_LO, 0);
		chk(rdata, 32'h5300);
		apb(1, `IDX_CONV, 32'h4);
		apb(1, `IDX_CTRL, 32'h0);
		repeat (2) @(posedge clk_in);
		chk(sequence_active_flag_out, 0);
		apb(0, `IDX_RES_LO, 0);
		chk(rdata, 0);
		apb(1, `IDX_CONV, 32'h4);
		repeat (20) @(posedge clk_in);
		chk(sequence_active_flag_out, 0);
		// synchronized: an idle sequencer reruns on a main start
		apb(1, `IDX_CTRL, 32'h50);
		apb(1, `IDX_CONV, 32'h5);
		wait_lvl(1, 10);
		wait_lvl(0, 100);
		n = cfg_seen.size();
		wait_lvl(1, 600);
		wait_lvl(0, 100);
		chk(cfg_seen.size(), n + 3);
		// chop on, settle code 0, overcurrent threshold 2
		fast_over_in <= 0;
		repeat (10) @(posedge clk_in);
		apb(1, `IDX_CTRL, 32'h2001);
		apb(1, `IDX_CONV, 32'h1);
		n = 0;
		// count fast results from the start's fast filter reset
		do begin
			@(posedge clk_in);
			n++;
		end while (fast_filter_rst_out !== 1'b1 && n < 50);
		fast_over_in <= 1;
		while (overcurrent_out !== 1'b1 && n < 300) begin
			@(posedge clk_in);
			n++;
			if (fast_done_in === 1'b1 && overcurrent_out !== 1'b1)
				fcnt++;
		end
		chk(fcnt, 4);
		chk(overcurrent_out, 1);
		while (main_drdy_out !== 1'b1 && n < 3000) begin
			@(posedge clk_in);
			n++;
		end
		// two cycles slack for the command latency
		chk(n >= 2 * (16 + 3 * 128) + 44 - 2 && n < 3000, 1);
		chk(main_result_out, 24'd200);
		chk(overcurrent_out, 1);
		// reset in mid-run returns control and outputs to defaults
		rst_in <= 1;
		repeat (2) @(posedge clk_in);
		rst_in <= 0;
		apb(0, `IDX_CTRL, 0);
		chk(rdata, `CTRL_RST);
		chk(overcurrent_out, 0);
		test_done;
	end
endmodule // chop_and_channel_sequencer_bench
